// >>> src/fps_flash_array.sv
module fps_flash_array (
  input wire logic aclk,
  input fps_pkg::fps_flash_req_s req,
  output logic [7:0] rdata
);

  // ------------------------------------------------------------
  // byte store: user rows then the supervisory row
  // ------------------------------------------------------------
  // non-volatile contents have no reset; erase before relying on them
  logic [7:0] mem_q [fps_pkg::FLASH_BYTES];

  always_ff @(posedge aclk) begin
    if (req.wr_en) begin
      mem_q[req.addr] <= req.wdata;
    end
    rdata <= mem_q[req.addr];
  end

endmodule

// >>> src/fps_pkg.sv
package fps_pkg;

  // ------------------------------------------------------------
  // flash geometry
  // ------------------------------------------------------------
  localparam int unsigned ROW_BYTES = 128;
  localparam int unsigned USER_ROWS = 8;
  localparam int unsigned TOTAL_ROWS = USER_ROWS + 1;
  localparam int unsigned FLASH_BYTES = TOTAL_ROWS * ROW_BYTES;
  localparam int unsigned FA_W = 11;
  localparam int unsigned BI_W = 7;
  localparam int unsigned PROT_SHIFT = 3;
  localparam logic [FA_W-1:0] SUPV_BASE = FA_W'(USER_ROWS * ROW_BYTES);
  localparam logic [FA_W-1:0] FLASH_LAST = FA_W'(FLASH_BYTES - 1);

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_ARG = 8'h00;
  localparam logic [7:0] ADDR_REQ = 8'h04;
  localparam logic [31:0] ARG_RESET = 32'h0000_0000;
  localparam int unsigned REQ_BIT = 31;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // call encodings
  // ------------------------------------------------------------
  localparam logic [15:0] OP_PROGRAM = 16'h0006;
  localparam logic [15:0] OP_ERASE_ALL = 16'h000A;
  localparam logic [15:0] OP_CHECKSUM = 16'h000B;
  localparam logic [7:0] FIRST_UNLOCK_KEY = 8'hB6;
  localparam logic [7:0] SECOND_UNLOCK_KEY_PROGRAM = 8'hD9;
  localparam logic [7:0] SECOND_UNLOCK_KEY_ERASE = 8'hDD;
  localparam logic [7:0] SECOND_UNLOCK_KEY_CHECKSUM = 8'hDE;
  localparam logic [15:0] SEL_WHOLE = 16'h8000;
  localparam logic [3:0] ST_SUCCESS = 4'hA;
  localparam logic [3:0] ST_FAIL = 4'hF;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_FETCH = 3'h1,
    S_DECODE = 3'h2,
    S_PROT_CHK = 3'h3,
    S_PROG = 3'h4,
    S_ERASE = 3'h5,
    S_SUM = 3'h6,
    S_SUM_LAST = 3'h7
  } fps_state_e;

  typedef struct packed {
    logic wr_en;
    logic [FA_W-1:0] addr;
    logic [7:0] wdata;
  } fps_flash_req_s;

endpackage

// >>> src/fps_syscall.sv
// What this block does
// - program row uses latch, row from param
// - all-zero latch skips programming
// - latch cleared after programming
// - protected row is never programmed
// - SRAM address in argument, then request; checksum passes its params in argument
// - erase-all clears user and protection data
// - erase-all only debug, programming, unlocked
// - unlock transition triggers full erase
// - checksum is 24-bit byte sum
// - whole checksum includes supervisory row
// - selector is row or 0x8000 whole
// - checksum returns status and sum
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
module fps_syscall (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sram_rd_req,
  output logic [31:0] sram_rd_addr,
  input wire logic sram_rd_ack,
  input wire logic [31:0] sram_rd_data,
  input wire logic latch_wr_en,
  input wire logic [6:0] latch_wr_idx,
  input wire logic [7:0] latch_wr_data,
  input wire logic call_from_debug,
  input wire logic programming_mode,
  input wire logic chip_unlocked,
  input wire logic unlock_erase_pulse,
  output logic busy
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic keys_ok(input logic [31:0] p,
                                   input logic [7:0] k2);
    keys_ok = (p[7:0] == fps_pkg::FIRST_UNLOCK_KEY) && (p[15:8] == k2);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  function automatic logic [fps_pkg::FA_W-1:0] row_base(
      input logic [15:0] row);
    row_base = fps_pkg::FA_W'({row, 7'h00});
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  fps_pkg::fps_state_e state_q, state_d;
  logic [31:0] arg_q, arg_d, param_q, param_d;
  logic [31:0] sram_addr_q, sram_addr_d, rdata_q, rdata_d;
  logic [31:0] req_new;
  logic [15:0] op_q, op_d;
  logic [fps_pkg::FA_W-1:0] idx_q, idx_d, end_q, end_d;
  logic [23:0] sum_q, sum_d, sum_last;
  logic dbg_q, dbg_d, auto_q, auto_d, pend_q, pend_d;
  logic rd_pend_q, rd_pend_d, sram_req_q, sram_req_d, busy_q, busy_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic wr_go, wr_arg, wr_req, latch_clr, latch_zero, row_ok, prot_bit;
  logic erase_ok;
  logic [7:0] latch_q [fps_pkg::ROW_BYTES];
  fps_pkg::fps_flash_req_s fl_req;
  logic [7:0] fl_rdata;

  fps_flash_array u_flash (
    .aclk(aclk),
    .req(fl_req),
    .rdata(fl_rdata)
  );

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign sram_rd_req = sram_req_q;
  assign sram_rd_addr = sram_addr_q;
  assign busy = busy_q;

  assign row_ok = param_q[31:16] < 16'(fps_pkg::USER_ROWS);
  assign prot_bit = fl_rdata[param_q[18:16]];
  assign sum_last = sum_q + 24'(fl_rdata);
  assign erase_ok = dbg_q && programming_mode && chip_unlocked;

  // ------------------------------------------------------------
  // page latch
  // ------------------------------------------------------------
  // loading is frozen while a row is being programmed from it
  always_ff @(posedge aclk) begin
    if (!aresetn || latch_clr) begin
      for (int i = 0; i < fps_pkg::ROW_BYTES; i++) begin
        latch_q[i] <= 8'h00;
      end
    end else if (latch_wr_en && state_q != fps_pkg::S_PROG) begin
      latch_q[latch_wr_idx] <= latch_wr_data;
    end
  end

  always_comb begin
    latch_zero = 1'b1;
    for (int i = 0; i < fps_pkg::ROW_BYTES; i++) begin
      if (latch_q[i] != 8'h00) begin
        latch_zero = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // bus slave and call sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    arg_d = arg_q;
    param_d = param_q;
    sram_addr_d = sram_addr_q;
    rdata_d = rdata_q;
    op_d = op_q;
    idx_d = idx_q;
    end_d = end_q;
    sum_d = sum_q;
    dbg_d = dbg_q;
    auto_d = auto_q;
    pend_d = pend_q;
    rd_pend_d = 1'b0;
    sram_req_d = sram_req_q;
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    latch_clr = 1'b0;
    fl_req = '{wr_en: 1'b0, addr: idx_q, wdata: 8'h00};

    wr_go = aw_have_q && w_have_q && !bvalid_q;
    wr_arg = wr_go && aw_addr_q == fps_pkg::ADDR_ARG;
    wr_req = wr_go && aw_addr_q == fps_pkg::ADDR_REQ;
    req_new = merge({busy_q, 15'h0000, op_q}, wdata_q, wstrb_q);
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d = (wr_arg || wr_req) ? fps_pkg::RESP_OKAY
                                   : fps_pkg::RESP_SLVERR;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = fps_pkg::RESP_OKAY;
      case (s_axi_araddr)
        fps_pkg::ADDR_ARG: rdata_d = arg_q;
        fps_pkg::ADDR_REQ: rdata_d = {busy_q, 15'h0000, op_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = fps_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;

    // writes to either register are ignored while a call runs
    case (state_q)
      fps_pkg::S_IDLE: begin
        if (pend_q) begin
          pend_d = 1'b0;
          auto_d = 1'b1;
          idx_d = '0;
          state_d = fps_pkg::S_ERASE;
        end else if (wr_req && req_new[fps_pkg::REQ_BIT]) begin
          op_d = req_new[15:0];
          dbg_d = call_from_debug;
          auto_d = 1'b0;
          if (req_new[15:0] == fps_pkg::OP_CHECKSUM) begin
            param_d = arg_q;
            state_d = fps_pkg::S_DECODE;
          end else begin
            sram_addr_d = arg_q;
            sram_req_d = 1'b1;
            state_d = fps_pkg::S_FETCH;
          end
        end else if (wr_arg) begin
          arg_d = merge(arg_q, wdata_q, wstrb_q);
        end
      end
      fps_pkg::S_FETCH: begin
        if (sram_rd_ack) begin
          param_d = sram_rd_data;
          sram_req_d = 1'b0;
          state_d = fps_pkg::S_DECODE;
        end
      end
      fps_pkg::S_DECODE: begin
        arg_d = {fps_pkg::ST_FAIL, 28'h000_0000};
        state_d = fps_pkg::S_IDLE;
        sum_d = '0;
        case (op_q)
          fps_pkg::OP_PROGRAM: begin
            if (keys_ok(param_q, fps_pkg::SECOND_UNLOCK_KEY_PROGRAM) && row_ok) begin
              fl_req.addr = fps_pkg::SUPV_BASE +
                fps_pkg::FA_W'(param_q[31:16] >> fps_pkg::PROT_SHIFT);
              arg_d = arg_q;
              state_d = fps_pkg::S_PROT_CHK;
            end
          end
          fps_pkg::OP_ERASE_ALL: begin
            if (keys_ok(param_q, fps_pkg::SECOND_UNLOCK_KEY_ERASE) && erase_ok) begin
              idx_d = '0;
              arg_d = arg_q;
              state_d = fps_pkg::S_ERASE;
            end
          end
          fps_pkg::OP_CHECKSUM: begin
            if (keys_ok(param_q, fps_pkg::SECOND_UNLOCK_KEY_CHECKSUM)) begin
              if (param_q[31:16] == fps_pkg::SEL_WHOLE) begin
                idx_d = '0;
                end_d = fps_pkg::FLASH_LAST;
                arg_d = arg_q;
                state_d = fps_pkg::S_SUM;
              end else if (row_ok) begin
                idx_d = row_base(param_q[31:16]);
                end_d = row_base(param_q[31:16]) +
                  fps_pkg::FA_W'(fps_pkg::ROW_BYTES - 1);
                arg_d = arg_q;
                state_d = fps_pkg::S_SUM;
              end
            end
          end
          default: ;
        endcase
      end
      fps_pkg::S_PROT_CHK: begin
        state_d = fps_pkg::S_IDLE;
        if (prot_bit) begin
          arg_d = {fps_pkg::ST_FAIL, 28'h000_0000};
        end else if (latch_zero) begin
          arg_d = {fps_pkg::ST_SUCCESS, 28'h000_0000};
        end else begin
          idx_d = row_base(param_q[31:16]);
          state_d = fps_pkg::S_PROG;
        end
      end
      fps_pkg::S_PROG: begin
        fl_req.wr_en = 1'b1;
        fl_req.wdata = latch_q[idx_q[fps_pkg::BI_W-1:0]];
        idx_d = idx_q + 1'b1;
        if (&idx_q[fps_pkg::BI_W-1:0]) begin
          latch_clr = 1'b1;
          arg_d = {fps_pkg::ST_SUCCESS, 28'h000_0000};
          state_d = fps_pkg::S_IDLE;
        end
      end
      fps_pkg::S_ERASE: begin
        // the supervisory row follows the user rows, so protection
        // bytes are wiped by the same sweep
        fl_req.wr_en = 1'b1;
        idx_d = idx_q + 1'b1;
        if (idx_q == fps_pkg::FLASH_LAST) begin
          state_d = fps_pkg::S_IDLE;
          if (!auto_q) begin
            arg_d = {fps_pkg::ST_SUCCESS, 28'h000_0000};
          end
        end
      end
      fps_pkg::S_SUM: begin
        rd_pend_d = 1'b1;
        if (rd_pend_q) begin
          sum_d = sum_last;
        end
        if (idx_q == end_q) begin
          state_d = fps_pkg::S_SUM_LAST;
        end else begin
          idx_d = idx_q + 1'b1;
        end
      end
      fps_pkg::S_SUM_LAST: begin
        arg_d = {fps_pkg::ST_SUCCESS, 4'h0, sum_last};
        state_d = fps_pkg::S_IDLE;
      end
      default: state_d = fps_pkg::S_IDLE;
    endcase

    // a transition arriving during a call is kept, not lost
    if (unlock_erase_pulse) begin
      pend_d = 1'b1;
    end
    busy_d = state_d != fps_pkg::S_IDLE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= fps_pkg::S_IDLE;
      arg_q <= fps_pkg::ARG_RESET;
      param_q <= 32'h0000_0000;
      sram_addr_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
      op_q <= 16'h0000;
      idx_q <= '0;
      end_q <= '0;
      sum_q <= 24'h00_0000;
      dbg_q <= 1'b0;
      auto_q <= 1'b0;
      pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      sram_req_q <= 1'b0;
      busy_q <= 1'b0;
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= fps_pkg::RESP_OKAY;
      rresp_q <= fps_pkg::RESP_OKAY;
    end else begin
      state_q <= state_d;
      arg_q <= arg_d;
      param_q <= param_d;
      sram_addr_q <= sram_addr_d;
      rdata_q <= rdata_d;
      op_q <= op_d;
      idx_q <= idx_d;
      end_q <= end_d;
      sum_q <= sum_d;
      dbg_q <= dbg_d;
      auto_q <= auto_d;
      pend_q <= pend_d;
      rd_pend_q <= rd_pend_d;
      sram_req_q <= sram_req_d;
      busy_q <= busy_d;
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_unlock;
    unlock_erase_pulse && state_q == fps_pkg::S_IDLE;
  endsequence

  sequence s_chk_open;
    state_q == fps_pkg::S_PROT_CHK && !prot_bit;
  endsequence

  AST_PROG_ROW: assert property (state_q == fps_pkg::S_PROG |->
    fl_req.addr[fps_pkg::FA_W-1:fps_pkg::BI_W] ==
    param_q[16 +: fps_pkg::FA_W-fps_pkg::BI_W])
    else $error("program writes outside the addressed row");
  AST_SKIP_ZERO: assert property (s_chk_open ##0 latch_zero |=>
    state_q == fps_pkg::S_IDLE && arg_q[31:28] == fps_pkg::ST_SUCCESS)
    else $error("all-zero latch did not skip programming");
  AST_LATCH_CLR: assert property (state_q == fps_pkg::S_PROG &&
    (&idx_q[fps_pkg::BI_W-1:0]) |=> latch_zero)
    else $error("latch not cleared after programming");
  AST_PROTECTED: assert property (state_q == fps_pkg::S_PROT_CHK &&
    prot_bit |=> state_q == fps_pkg::S_IDLE &&
    arg_q[31:28] == fps_pkg::ST_FAIL)
    else $error("protected row was not refused");
  AST_ERASE_GATE: assert property (state_q == fps_pkg::S_DECODE &&
    op_q == fps_pkg::OP_ERASE_ALL && !erase_ok |=>
    state_q == fps_pkg::S_IDLE && arg_q[31:28] == fps_pkg::ST_FAIL)
    else $error("erase-all accepted outside its conditions");
  AST_ERASE_END: assert property (state_q == fps_pkg::S_ERASE |->
    fl_req.wr_en && fl_req.wdata == 8'h00 ##1
    (state_q != fps_pkg::S_ERASE) == ($past(idx_q) == fps_pkg::FLASH_LAST))
    else $error("erase sweep wrong data or length");
  AST_UNLOCK: assert property (s_unlock ##1 state_q == fps_pkg::S_IDLE
    |=> state_q == fps_pkg::S_ERASE)
    else $error("unlock did not start a full erase");
  AST_CSUM: assert property (state_q == fps_pkg::S_SUM_LAST |=>
    arg_q[31:28] == fps_pkg::ST_SUCCESS && arg_q[23:0] == $past(sum_last))
    else $error("checksum result not returned");
  AST_KEY_FAIL: assert property (state_q == fps_pkg::S_DECODE &&
    op_q == fps_pkg::OP_CHECKSUM &&
    !keys_ok(param_q, fps_pkg::SECOND_UNLOCK_KEY_CHECKSUM) |=>
    arg_q[31:28] == fps_pkg::ST_FAIL && state_q == fps_pkg::S_IDLE)
    else $error("bad checksum key not refused");

endmodule

// >>> test/fps_sram_model.sv
module fps_sram_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sram_rd_req,
  input wire logic [31:0] sram_rd_addr,
  output logic sram_rd_ack,
  output logic [31:0] sram_rd_data,
  input wire logic [31:0] param_addr,
  input wire logic [31:0] param_word,
  input wire logic [3:0] lag
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] cnt_q;

  // ------------------------------------------------------------
  // parameter store, answers after lag cycles
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      sram_rd_ack <= 1'b0;
      sram_rd_data <= 32'h5A5A_5A5A;
      cnt_q <= 4'h0;
    end else if (sram_rd_ack || !sram_rd_req) begin
      // data is flipped when not answering so a stale word never passes
      sram_rd_ack <= 1'b0;
      sram_rd_data <= ~sram_rd_data;
      cnt_q <= 4'h0;
    end else if (cnt_q >= lag) begin
      sram_rd_ack <= 1'b1;
      sram_rd_data <= (sram_rd_addr === param_addr) ? param_word :
                      ~param_word;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// >>> test/fps_syscall_tb_top.sv
module fps_syscall_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic aclk, aresetn, busy;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, raddr, rdat, p_addr, p_word, res;
  logic [3:0] wstrb, lag;
  logic [1:0] bresp, rresp, rr;
  logic req, ack, lwe, dbg, pmode, unl, upulse;
  logic [6:0] lidx;
  logic [7:0] ldat;
  logic [23:0] row_sum;
  int fails, cmp_count;

  fps_syscall fps_syscall_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sram_rd_req(req), .sram_rd_addr(raddr), .sram_rd_ack(ack),
    .sram_rd_data(rdat), .latch_wr_en(lwe), .latch_wr_idx(lidx),
    .latch_wr_data(ldat), .call_from_debug(dbg), .programming_mode(pmode),
    .chip_unlocked(unl), .unlock_erase_pulse(upulse), .busy(busy)
  );

  fps_sram_model fps_sram_model_i (
    .aclk(aclk), .aresetn(aresetn), .sram_rd_req(req),
    .sram_rd_addr(raddr), .sram_rd_ack(ack), .sram_rd_data(rdat),
    .param_addr(p_addr), .param_word(p_word), .lag(lag)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    bit aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 3000) begin
      fails++;
      $display("MISMATCH busy expected %b seen %b", lvl, busy);
    end
  endtask

  // every call: argument, then request with the call bit, then poll
  task automatic do_call(input logic [31:0] arg, input logic [15:0] op);
    axi_wr(fps_pkg::ADDR_ARG, arg, fps_pkg::RESP_OKAY);
    axi_wr(fps_pkg::ADDR_REQ, {16'h8000, op}, fps_pkg::RESP_OKAY);
    wait_busy(1'b0);
    axi_rd(fps_pkg::ADDR_ARG, res, rr);
  endtask

  function automatic logic [31:0] ck(input logic [15:0] sel,
                                     input logic [7:0] k2);
    return {sel, k2, fps_pkg::FIRST_UNLOCK_KEY};
  endfunction

  function automatic logic [31:0] ok(input logic [23:0] s);
    return {fps_pkg::ST_SUCCESS, 4'h0, s};
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_map();
    axi_rd(fps_pkg::ADDR_ARG, res, rr);
    chk("arg reset", fps_pkg::ARG_RESET, res);
    axi_rd(fps_pkg::ADDR_REQ, res, rr);
    chk("req reset", 32'h0000_0000, res);
    axi_rd(8'h08, res, rr);
    chk("rresp unmapped", {30'h0, fps_pkg::RESP_SLVERR}, {30'h0, rr});
    axi_wr(8'h0C, 32'h1234_5678, fps_pkg::RESP_SLVERR);
  endtask

  task automatic t_erase();
    p_word <= ck(16'h0000, fps_pkg::SECOND_UNLOCK_KEY_ERASE);
    do_call(p_addr, fps_pkg::OP_ERASE_ALL);
    chk("erase status", ok(24'h0), res);
    do_call(ck(fps_pkg::SEL_WHOLE, fps_pkg::SECOND_UNLOCK_KEY_CHECKSUM),
            fps_pkg::OP_CHECKSUM);
    chk("sum erased", ok(24'h0), res);
  endtask

  task automatic t_program();
    logic [7:0] b;
    row_sum = 24'h0;
    for (int i = 0; i < 128; i++) begin
      b = 8'(i * 37 + 11);
      row_sum = row_sum + {16'h0, b};
      @(posedge aclk);
      lwe <= 1'b1;
      lidx <= 7'(i);
      ldat <= b;
    end
    @(posedge aclk);
    lwe <= 1'b0;
    lag <= 4'h6;
    p_word <= ck(16'h0003, fps_pkg::SECOND_UNLOCK_KEY_PROGRAM);
    do_call(p_addr, fps_pkg::OP_PROGRAM);
    chk("program status", ok(24'h0), res);
    do_call(ck(16'h0003, fps_pkg::SECOND_UNLOCK_KEY_CHECKSUM), fps_pkg::OP_CHECKSUM);
    chk("sum row3", ok(row_sum), res);
    do_call(ck(16'h0002, fps_pkg::SECOND_UNLOCK_KEY_CHECKSUM), fps_pkg::OP_CHECKSUM);
    chk("sum row2", ok(24'h0), res);
    do_call(ck(fps_pkg::SEL_WHOLE, fps_pkg::SECOND_UNLOCK_KEY_CHECKSUM),
            fps_pkg::OP_CHECKSUM);
    chk("sum whole", ok(row_sum), res);
    lag <= 4'h0;
  endtask

  // the latch must now be empty, so this call writes nothing
  task automatic t_skip();
    p_word <= ck(16'h0004, fps_pkg::SECOND_UNLOCK_KEY_PROGRAM);
    do_call(p_addr, fps_pkg::OP_PROGRAM);
    chk("skip status", ok(24'h0), res);
    do_call(ck(16'h0004, fps_pkg::SECOND_UNLOCK_KEY_CHECKSUM), fps_pkg::OP_CHECKSUM);
    chk("sum row4", ok(24'h0), res);
  endtask

  task automatic t_refuse();
    logic [2:0] cond [3] = '{3'b011, 3'b101, 3'b110};
    do_call(ck(16'h0003, 8'hDF), fps_pkg::OP_CHECKSUM);
    chk("bad second_unlock_key", {fps_pkg::ST_FAIL, 28'h0}, res);
    do_call(ck(16'h0008, fps_pkg::SECOND_UNLOCK_KEY_CHECKSUM), fps_pkg::OP_CHECKSUM);
    chk("bad row", {fps_pkg::ST_FAIL, 28'h0}, res);
    p_word <= {16'h0005, fps_pkg::SECOND_UNLOCK_KEY_PROGRAM, 8'hB7};
    do_call(p_addr, fps_pkg::OP_PROGRAM);
    chk("bad first_unlock_key", {fps_pkg::ST_FAIL, 28'h0}, res);
    // an opcode outside the three calls still fetches, then fails
    do_call(p_addr, 16'h000C);
    chk("bad opcode", {fps_pkg::ST_FAIL, 28'h0}, res);
    p_word <= ck(16'h0000, fps_pkg::SECOND_UNLOCK_KEY_ERASE);
    for (int i = 0; i < 3; i++) begin
      {dbg, pmode, unl} <= cond[i];
      do_call(p_addr, fps_pkg::OP_ERASE_ALL);
      chk("erase refused", {fps_pkg::ST_FAIL, 28'h0}, res);
    end
    {dbg, pmode, unl} <= 3'b111;
    do_call(ck(16'h0003, fps_pkg::SECOND_UNLOCK_KEY_CHECKSUM), fps_pkg::OP_CHECKSUM);
    chk("sum kept", ok(row_sum), res);
  endtask

  task automatic t_unlock();
    @(posedge aclk);
    upulse <= 1'b1;
    @(posedge aclk);
    upulse <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    axi_rd(fps_pkg::ADDR_ARG, res, rr);
    chk("arg after sweep", ok(row_sum), res);
    do_call(ck(fps_pkg::SEL_WHOLE, fps_pkg::SECOND_UNLOCK_KEY_CHECKSUM),
            fps_pkg::OP_CHECKSUM);
    chk("sum swept", ok(24'h0), res);
  endtask

  // ------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    // the whole sequence needs well under 10k cycles
    #120000;
    fails++;
    results();
  end

  initial begin
    fails = 0;
    cmp_count = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, lwe, upulse} = 7'h00;
    {awaddr, araddr, lidx, ldat} = 31'h0;
    {wdata, wstrb, lag} = 40'h0;
    {dbg, pmode, unl} = 3'b111;
    p_addr = 32'h0000_0100;
    p_word = 32'h0000_0000;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_map();
    t_erase();
    t_program();
    t_skip();
    t_refuse();
    t_unlock();
    results();
  end
endmodule
